// File: design/sacw_top.sv
// Purpose: Control around a 10-bit successive-approximation converter
// Assumes: Timer overflows are one-cycle pulses on ref_clk; the core result
//          is stable when the last converter clock of a conversion ends
// Notes:   Reads return data one cycle after the read strobe
//
// Summary of operation
// - Converter clock is system clock over divider+1
// - Gain code maps to 1,2,4,8,16,0.5
// - Enable low keeps converter shut down
// - Normal mode tracks whenever not converting
// - Start source selects software, timers or pin
// - Low-power internal start tracks three converter clocks
// - Low-power pin mode tracks while pin low
// - Busy shows low-power track and conversion; its fall at conversion end sets done
// - Busy write starts only with software source
// - Done flag held until software clears it
// - Window flag held until software clears it
// - Right justify: sign-extend differential, else zeros
// - Left justify: low six bits read zero
// - Single-ended unsigned, differential two's-complement
// - Compare each result with both limit words
// - Inside window when greater below less
// - Compare justified word, signed for differential
`timescale 1ns/1ps
`default_nettype none

module sacw_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Start sources
    input wire logic timer3_overflow,
    input wire logic timer2_overflow,
    input wire logic external_convert_start,
    // Analog core
    input wire logic [9:0] core_result,
    input wire logic core_differential,
    output sacw_pkg::sacw_core_t core_ctl
);

    // ==========================================================
    // State
    logic [7:0] converter_config;
    sacw_pkg::sacw_ctrl_t converter_control;
    logic [15:0] result_word;
    logic [15:0] greater_limit;
    logic [15:0] less_limit;
    sacw_pkg::sacw_state_t state;
    logic [4:0] div_cnt;
    logic [4:0] sar_cnt;
    logic sar_clk;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [7:0] rdata;

    logic [7:0] next_converter_config;
    sacw_pkg::sacw_ctrl_t next_converter_control;
    logic [15:0] next_result_word;
    logic [15:0] next_greater_limit;
    logic [15:0] next_less_limit;
    sacw_pkg::sacw_state_t next_state;
    logic [4:0] next_div_cnt;
    logic [4:0] next_sar_cnt;
    logic next_sar_clk;
    logic [7:0] next_rdata;

    // ==========================================================
    // Decoded helpers
    logic [4:0] divider;
    logic sar_tick;
    logic ext_rise;
    logic start_event;
    logic conv_end;
    logic [15:0] justified;
    logic window_hit;
    logic wr_ctl;

    assign divider = converter_config[7:sacw_pkg::CFG_DIV_LSB];
    assign sar_tick = (div_cnt == divider);
    assign ext_rise = ext_s2 && !ext_s3;
    assign wr_ctl = sfr_wr && (sfr_addr == sacw_pkg::ADDR_CONVERTER_CONTROL);
    assign conv_end = (state == sacw_pkg::ST_CONVERT) && sar_tick
        && (sar_cnt == sacw_pkg::CONVERT_SAR_CLOCKS - 5'h01);

    // Start event picked by the source field; other sources are ignored
    always_comb begin
        start_event = 1'b0;
        case (converter_control.start_source_select)
            sacw_pkg::SRC_SOFTWARE: start_event = wr_ctl && sfr_wdata[sacw_pkg::CTL_BUSY];
            sacw_pkg::SRC_TIMER3: start_event = timer3_overflow;
            sacw_pkg::SRC_EXTERNAL: start_event = ext_rise;
            sacw_pkg::SRC_TIMER2: start_event = timer2_overflow;
            default: start_event = 1'b0;
        endcase
    end

    // Justify the fresh code; differential codes extend their sign bit
    always_comb begin
        if (converter_control.left_justify_select) begin
            justified = {core_result, 6'h00};
        end else if (core_differential) begin
            justified = {{6{core_result[9]}}, core_result};
        end else begin
            justified = {6'h00, core_result};
        end
    end

    // Window test on the justified word; signed only for differential data
    always_comb begin
        logic gt_ok;
        logic lt_ok;
        logic lim_inv;
        gt_ok = 1'b0;
        lt_ok = 1'b0;
        lim_inv = 1'b0;
        if (core_differential) begin
            gt_ok = $signed(justified) > $signed(greater_limit);
            lt_ok = $signed(justified) < $signed(less_limit);
            lim_inv = $signed(greater_limit) < $signed(less_limit);
        end else begin
            gt_ok = justified > greater_limit;
            lt_ok = justified < less_limit;
            lim_inv = greater_limit < less_limit;
        end
        window_hit = lim_inv ? (gt_ok && lt_ok) : (gt_ok || lt_ok);
    end

    // ==========================================================
    // Converter clock divider, held at zero while shut down
    always_comb begin
        next_div_cnt = 5'h00;
        next_sar_clk = 1'b0;
        if (converter_control.converter_enable) begin
            next_div_cnt = sar_tick ? 5'h00 : div_cnt + 5'h01;
            next_sar_clk = (next_div_cnt <= {1'b0, divider[4:1]});
        end
    end

    // ==========================================================
    // Sequencer: idle, optional low-power track, then conversion
    always_comb begin
        next_state = state;
        next_sar_cnt = sar_cnt;
        case (state)
            sacw_pkg::ST_IDLE: begin
                next_sar_cnt = 5'h00;
                if (converter_control.converter_enable && start_event) begin
                    if (converter_control.low_power_track_select
                            && converter_control.start_source_select != sacw_pkg::SRC_EXTERNAL) begin
                        next_state = sacw_pkg::ST_TRACK;
                    end else begin
                        next_state = sacw_pkg::ST_CONVERT;
                    end
                end
            end
            sacw_pkg::ST_TRACK: begin
                if (sar_tick) begin
                    if (sar_cnt == sacw_pkg::TRACK_SAR_CLOCKS - 5'h01) begin
                        next_state = sacw_pkg::ST_CONVERT;
                        next_sar_cnt = 5'h00;
                    end else begin
                        next_sar_cnt = sar_cnt + 5'h01;
                    end
                end
            end
            sacw_pkg::ST_CONVERT: begin
                if (conv_end) begin
                    next_state = sacw_pkg::ST_IDLE;
                    next_sar_cnt = 5'h00;
                end else if (sar_tick) begin
                    next_sar_cnt = sar_cnt + 5'h01;
                end
            end
            default: begin
                next_state = sacw_pkg::ST_IDLE;
                next_sar_cnt = 5'h00;
            end
        endcase
        // Shutting down abandons a conversion without touching results
        if (!converter_control.converter_enable) begin
            next_state = sacw_pkg::ST_IDLE;
            next_sar_cnt = 5'h00;
        end
    end

    // ==========================================================
    // Register file writes and hardware flag updates
    always_comb begin
        next_converter_config = converter_config;
        next_converter_control = converter_control;
        next_result_word = result_word;
        next_greater_limit = greater_limit;
        next_less_limit = less_limit;
        if (sfr_wr) begin
            case (sfr_addr)
                sacw_pkg::ADDR_CONVERTER_CONFIG: next_converter_config = sfr_wdata;
                sacw_pkg::ADDR_RESULT_HIGH: next_result_word[15:8] = sfr_wdata;
                sacw_pkg::ADDR_RESULT_LOW: next_result_word[7:0] = sfr_wdata;
                sacw_pkg::ADDR_GREATER_LIMIT_HIGH: next_greater_limit[15:8] = sfr_wdata;
                sacw_pkg::ADDR_GREATER_LIMIT_LOW: next_greater_limit[7:0] = sfr_wdata;
                sacw_pkg::ADDR_LESS_LIMIT_HIGH: next_less_limit[15:8] = sfr_wdata;
                sacw_pkg::ADDR_LESS_LIMIT_LOW: next_less_limit[7:0] = sfr_wdata;
                sacw_pkg::ADDR_CONVERTER_CONTROL: begin
                    // Busy is not stored from the bus; a zero write does nothing
                    next_converter_control.converter_enable = sfr_wdata[sacw_pkg::CTL_ENABLE];
                    next_converter_control.low_power_track_select = sfr_wdata[sacw_pkg::CTL_LOW_POWER];
                    next_converter_control.conversion_done_flag = sfr_wdata[sacw_pkg::CTL_DONE];
                    next_converter_control.start_source_select =
                        sacw_pkg::sacw_src_t'(sfr_wdata[sacw_pkg::CTL_SRC_LSB +: 2]);
                    next_converter_control.window_match_flag = sfr_wdata[sacw_pkg::CTL_WINDOW];
                    next_converter_control.left_justify_select = sfr_wdata[sacw_pkg::CTL_LEFT];
                end
                default: begin
                end
            endcase
        end
        // Conversion end lands after bus writes so a set beats a same-cycle clear
        if (conv_end) begin
            next_result_word = justified;
            next_converter_control.conversion_done_flag = 1'b1;
            if (window_hit) begin
                next_converter_control.window_match_flag = 1'b1;
            end
        end
        next_converter_control.conversion_busy = (next_state != sacw_pkg::ST_IDLE);
    end

    // ==========================================================
    // Read data, registered one cycle after the strobe
    always_comb begin
        next_rdata = rdata;
        if (sfr_rd) begin
            case (sfr_addr)
                sacw_pkg::ADDR_CONVERTER_CONFIG: next_rdata = converter_config;
                sacw_pkg::ADDR_RESULT_HIGH: next_rdata = result_word[15:8];
                sacw_pkg::ADDR_RESULT_LOW: next_rdata = result_word[7:0];
                sacw_pkg::ADDR_GREATER_LIMIT_HIGH: next_rdata = greater_limit[15:8];
                sacw_pkg::ADDR_GREATER_LIMIT_LOW: next_rdata = greater_limit[7:0];
                sacw_pkg::ADDR_LESS_LIMIT_HIGH: next_rdata = less_limit[15:8];
                sacw_pkg::ADDR_LESS_LIMIT_LOW: next_rdata = less_limit[7:0];
                sacw_pkg::ADDR_CONVERTER_CONTROL: next_rdata = converter_control;
                default: next_rdata = sacw_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // ==========================================================
    // Flip-flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            converter_config <= sacw_pkg::RST_CONVERTER_CONFIG;
            converter_control <= sacw_pkg::RST_CONVERTER_CONTROL;
            result_word <= sacw_pkg::RST_RESULT;
            greater_limit <= sacw_pkg::RST_GREATER_LIMIT;
            less_limit <= sacw_pkg::RST_LESS_LIMIT;
            state <= sacw_pkg::ST_IDLE;
            div_cnt <= 5'h00;
            sar_cnt <= 5'h00;
            sar_clk <= 1'b0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            rdata <= 8'h00;
        end else begin
            converter_config <= next_converter_config;
            converter_control <= next_converter_control;
            result_word <= next_result_word;
            greater_limit <= next_greater_limit;
            less_limit <= next_less_limit;
            state <= next_state;
            div_cnt <= next_div_cnt;
            sar_cnt <= next_sar_cnt;
            sar_clk <= next_sar_clk;
            ext_s1 <= external_convert_start; // Pin is asynchronous
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Outputs toward the analog core
    always_comb begin
        core_ctl.powered = converter_control.converter_enable;
        core_ctl.converting = (state == sacw_pkg::ST_CONVERT);
        core_ctl.sar_clk = sar_clk;
        if (!converter_control.converter_enable) begin
            core_ctl.tracking = 1'b0;
        end else if (!converter_control.low_power_track_select) begin
            core_ctl.tracking = (state != sacw_pkg::ST_CONVERT);
        end else if (converter_control.start_source_select == sacw_pkg::SRC_EXTERNAL) begin
            core_ctl.tracking = (state == sacw_pkg::ST_IDLE) && !ext_s2;
        end else begin
            core_ctl.tracking = (state == sacw_pkg::ST_TRACK);
        end
        // Both 10x and 11x collapse, the low bit is don't-care there
        case (converter_config[sacw_pkg::CFG_GAIN_LSB +: 3])
            3'h0: core_ctl.gain = sacw_pkg::GAIN_1;
            3'h1: core_ctl.gain = sacw_pkg::GAIN_2;
            3'h2: core_ctl.gain = sacw_pkg::GAIN_4;
            3'h3: core_ctl.gain = sacw_pkg::GAIN_8;
            3'h4, 3'h5: core_ctl.gain = sacw_pkg::GAIN_16;
            default: core_ctl.gain = sacw_pkg::GAIN_HALF;
        endcase
    end

    assign sfr_rdata = rdata;

endmodule

`default_nettype wire

// File: design/sacw_pkg.sv
// Purpose: Shared constants and types for the SAR converter control block
// Assumes: Byte-wide special-function register port, one 40 MHz clock
// Notes:   Every offset, field position, reset value and count lives here
package sacw_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_CONVERTER_CONFIG = 8'hbc;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbf;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hbe;
    localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'he8;
    localparam logic [7:0] ADDR_GREATER_LIMIT_LOW = 8'hc4;
    localparam logic [7:0] ADDR_GREATER_LIMIT_HIGH = 8'hc5;
    localparam logic [7:0] ADDR_LESS_LIMIT_LOW = 8'hc6;
    localparam logic [7:0] ADDR_LESS_LIMIT_HIGH = 8'hc7;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CONVERTER_CONFIG = 8'hf8;
    localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [15:0] RST_GREATER_LIMIT = 16'hffff;
    localparam logic [15:0] RST_LESS_LIMIT = 16'h0000;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ==========================================================
    // Field positions
    localparam int CFG_DIV_LSB = 3;
    localparam int CFG_GAIN_LSB = 0;
    localparam int CTL_ENABLE = 7;
    localparam int CTL_LOW_POWER = 6;
    localparam int CTL_DONE = 5;
    localparam int CTL_BUSY = 4;
    localparam int CTL_SRC_LSB = 2;
    localparam int CTL_WINDOW = 1;
    localparam int CTL_LEFT = 0;

    // ==========================================================
    // Timing counts, in converter clocks
    localparam logic [4:0] TRACK_SAR_CLOCKS = 5'h03;
    localparam logic [4:0] CONVERT_SAR_CLOCKS = 5'h10;

    // ==========================================================
    // Start source codes
    typedef enum logic [1:0] {
        SRC_SOFTWARE = 2'h0,
        SRC_TIMER3 = 2'h1,
        SRC_EXTERNAL = 2'h2,
        SRC_TIMER2 = 2'h3
    } sacw_src_t;

    // Amplifier gain, decoded from the select code
    typedef enum logic [2:0] {
        GAIN_1 = 3'h0,
        GAIN_2 = 3'h1,
        GAIN_4 = 3'h2,
        GAIN_8 = 3'h3,
        GAIN_16 = 3'h4,
        GAIN_HALF = 3'h5
    } sacw_gain_t;

    // Conversion sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_TRACK = 3'h2,
        ST_CONVERT = 3'h4
    } sacw_state_t;

    // Control register fields
    typedef struct packed {
        logic converter_enable;
        logic low_power_track_select;
        logic conversion_done_flag;
        logic conversion_busy;
        sacw_src_t start_source_select;
        logic window_match_flag;
        logic left_justify_select;
    } sacw_ctrl_t;

    // Strobes toward the analog core
    typedef struct packed {
        logic powered;
        logic tracking;
        logic converting;
        logic sar_clk;
        sacw_gain_t gain;
    } sacw_core_t;

endpackage

// File: tb/sacw_core_model.sv
// Purpose: Behavioural stand-in for the analog multiplexer and converter core
// Assumes: The bench sets the code and the input pairing before each start
// Notes:   Outside a conversion the result lines show the inverse code
`timescale 1ns/1ps
`default_nettype none

module sacw_core_model (
    // Control from the block
    input wire sacw_pkg::sacw_core_t core_ctl,
    // Bench setup
    input wire logic [9:0] code,
    input wire logic differential,
    // Toward the block
    output logic [9:0] core_result,
    output logic core_differential
);
    // =====================================================
    // Core outputs
    // A stale code is never shown, so a capture outside the conversion is caught
    assign core_result = core_ctl.converting ? code : ~code;
    assign core_differential = differential;
endmodule

`default_nettype wire

// File: tb/sacw_top_checker.sv
// Purpose: Port-level checks for the SAR converter control block
// Assumes: Software-owned control fields are shadowed from register writes
// Notes:   Length checks assume the divider is not rewritten mid-conversion
`timescale 1ns/1ps
`default_nettype none

module sacw_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    // Start sources and core
    input wire logic timer3_overflow,
    input wire logic timer2_overflow,
    input wire sacw_pkg::sacw_core_t core_ctl
);
    // =====================================================
    // Shadow state
    logic [4:0] div, next_div;
    logic en, next_en, lp, next_lp, cfg_wr, ctl_wr;
    logic [1:0] src, next_src;
    logic [9:0] conv_cnt, next_conv_cnt, trk_cnt, next_trk_cnt;

    // Only software changes these fields, so no hardware path is modelled
    always_comb begin
        cfg_wr = sfr_wr && sfr_addr == sacw_pkg::ADDR_CONVERTER_CONFIG;
        ctl_wr = sfr_wr && sfr_addr == sacw_pkg::ADDR_CONVERTER_CONTROL;
        next_div = cfg_wr ? sfr_wdata[7:3] : div;
        next_en = ctl_wr ? sfr_wdata[7] : en;
        next_lp = ctl_wr ? sfr_wdata[6] : lp;
        next_src = ctl_wr ? sfr_wdata[3:2] : src;
        next_conv_cnt = core_ctl.converting ? conv_cnt + 10'h001 : 10'h000;
        next_trk_cnt = core_ctl.tracking ? trk_cnt + 10'h001 : 10'h000;
    end

    // Register the shadows and run-length counters
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div <= 5'h1f;
            en <= 1'b0;
            lp <= 1'b0;
            src <= 2'h0;
            conv_cnt <= 10'h000;
            trk_cnt <= 10'h000;
        end else begin
            div <= next_div;
            en <= next_en;
            lp <= next_lp;
            src <= next_src;
            conv_cnt <= next_conv_cnt;
            trk_cnt <= next_trk_cnt;
        end
    end

    // =====================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_enable;
        ctl_wr |=> core_ctl.powered == $past(sfr_wdata[7]);
    endproperty
    a_enable: assert property (p_enable) else $error("power did not follow enable write");
    property p_gain;
        cfg_wr |=> core_ctl.gain == ($past(sfr_wdata[2]) ? ($past(sfr_wdata[1]) ? sacw_pkg::GAIN_HALF
            : sacw_pkg::GAIN_16) : sacw_pkg::sacw_gain_t'($past(sfr_wdata[2:0])));
    endproperty
    a_gain: assert property (p_gain) else $error("gain decode wrong");
    property p_track_gap;
        core_ctl.converting |-> !core_ctl.tracking;
    endproperty
    a_track_gap: assert property (p_track_gap) else $error("tracking during conversion");
    property p_normal_track;
        en && !lp && !core_ctl.converting |-> core_ctl.tracking;
    endproperty
    a_normal_track: assert property (p_normal_track) else $error("idle input not tracked");
    property p_soft_start;
        ctl_wr && sfr_wdata[7] && sfr_wdata[4] && en && !lp && src == sacw_pkg::SRC_SOFTWARE
            && !core_ctl.converting |=> core_ctl.converting;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("busy write did not start");
    property p_timer_start;
        en && !lp && !core_ctl.converting && (src == sacw_pkg::SRC_TIMER3 && timer3_overflow
            || src == sacw_pkg::SRC_TIMER2 && timer2_overflow) |=> core_ctl.converting;
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer overflow did not start");
    property p_length;
        $fell(core_ctl.converting) && core_ctl.powered |-> conv_cnt >= 15 * (div + 1) + 1
            && conv_cnt <= 16 * (div + 1);
    endproperty
    a_length: assert property (p_length) else $error("conversion length off");
    property p_lp_track;
        $fell(core_ctl.tracking) && $past(lp) && lp && src != sacw_pkg::SRC_EXTERNAL && div == 5'h00
            |-> core_ctl.converting && trk_cnt == 10'h003;
    endproperty
    a_lp_track: assert property (p_lp_track) else $error("low-power track length off");
endmodule

bind sacw_top sacw_checker i_checker (.ref_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .timer3_overflow,
    .timer2_overflow, .core_ctl);

`default_nettype wire

// File: tb/test_sar_adc_control_window.sv
// Purpose: Self-checking bench for the SAR converter control block
// Assumes: Inputs change 1 ns after the rising edge; reads answer next edge
// Notes:   Divider kept small so every conversion stays short
`timescale 1ns/1ps
`default_nettype none

module test_sar_adc_control_window;
    // =====================================================
    // Signals
    logic ref_clk = 1'b0, arst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv;
    logic timer3_overflow = 1'b0, timer2_overflow = 1'b0, external_convert_start = 1'b0;
    logic [9:0] core_result, model_code = 10'h000;
    logic core_differential, model_diff = 1'b0;
    sacw_pkg::sacw_core_t core_ctl;
    int miscompares = 0, checked = 0;
    localparam logic [7:0] CFG = sacw_pkg::ADDR_CONVERTER_CONFIG, CTL = sacw_pkg::ADDR_CONVERTER_CONTROL;
    localparam logic [2:0] GMAP [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5};
    typedef struct packed {
        logic [9:0] code; logic diff; logic left; logic pre;
        logic [15:0] gt; logic [15:0] lt; logic [15:0] word; logic win;
    } sacw_row_t;
    localparam sacw_row_t ROWS [8] = '{
        '{10'h3ff, 1'b0, 1'b0, 1'b0, 16'hffff, 16'h0000, 16'h03ff, 1'b0},
        '{10'h200, 1'b1, 1'b0, 1'b0, 16'hffff, 16'h0000, 16'hfe00, 1'b0},
        '{10'h3ff, 1'b0, 1'b1, 1'b0, 16'hffff, 16'h0000, 16'hffc0, 1'b0},
        '{10'h001, 1'b1, 1'b1, 1'b0, 16'hffc0, 16'h4000, 16'h0040, 1'b1},
        '{10'h3ff, 1'b1, 1'b1, 1'b1, 16'hffc0, 16'h4000, 16'hffc0, 1'b1},
        '{10'h1ff, 1'b1, 1'b1, 1'b0, 16'h4000, 16'hffc0, 16'h7fc0, 1'b1},
        '{10'h100, 1'b0, 1'b0, 1'b0, 16'h0080, 16'h0200, 16'h0100, 1'b1},
        '{10'h001, 1'b0, 1'b0, 1'b0, 16'h0080, 16'h0200, 16'h0001, 1'b0}};

    // Clock at 40 MHz
    always #12.5 ref_clk = ~ref_clk;

    // Design and analog partner
    sacw_top i_dut (.ref_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .timer3_overflow,
        .timer2_overflow, .external_convert_start, .core_result, .core_differential, .core_ctl);
    sacw_core_model i_core (.core_ctl, .code(model_code), .differential(model_diff), .core_result,
        .core_differential);

    // =====================================================
    // Tasks
    // Strobe held through the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr = 1'b0;
    endtask

    // Data is registered at the taking edge
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_rd = 1'b0;
        rv = sfr_rdata;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(rv, exp);
    endtask

    // One-cycle timer pulse, or a pin rise that stays high
    task automatic fire(input int s);
        @(posedge ref_clk);
        #1;
        timer3_overflow = (s == 1);
        timer2_overflow = (s == 3);
        external_convert_start = (s == 2);
        @(posedge ref_clk);
        #1;
        timer3_overflow = 1'b0;
        timer2_overflow = 1'b0;
    endtask

    // Polls the done flag, as software would, under a bound
    task automatic wait_done(input int bound);
        int n = 0;
        rv = 8'h00;
        while (rv[5] !== 1'b1) begin
            if (n == bound) begin
                miscompares++;
                $display("MISMATCH at %0t: conversion never finished", $time);
                complete_run();
            end
            rd(CTL);
            n++;
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // =====================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        rdchk(CFG, 8'hf8);
        rdchk(CTL, 8'h00);
        rdchk(sacw_pkg::ADDR_RESULT_HIGH, 8'h00);
        rdchk(8'h00, sacw_pkg::READ_UNMAPPED);
        $display("reset test done");
        for (int g = 0; g < 8; g++) begin
            wr(CFG, {5'h00, g[2:0]});
            chk({5'h00, core_ctl.gain}, {5'h00, GMAP[g]});
        end
        $display("gain test done");
        // Each row loads limits, converts one code and reads the justified word back
        for (int i = 0; i < 8; i++) begin
            model_code = ROWS[i].code;
            model_diff = ROWS[i].diff;
            wr(sacw_pkg::ADDR_GREATER_LIMIT_LOW, ROWS[i].gt[7:0]);
            wr(sacw_pkg::ADDR_GREATER_LIMIT_HIGH, ROWS[i].gt[15:8]);
            wr(sacw_pkg::ADDR_LESS_LIMIT_LOW, ROWS[i].lt[7:0]);
            wr(sacw_pkg::ADDR_LESS_LIMIT_HIGH, ROWS[i].lt[15:8]);
            wr(CTL, {6'h20, ROWS[i].pre, ROWS[i].left});
            wr(CTL, {6'h24, ROWS[i].pre, ROWS[i].left});
            rdchk(CTL, {6'h24, ROWS[i].pre, ROWS[i].left});
            chk({7'h00, core_ctl.sar_clk}, 8'h01);
            wait_done(40);
            chk(rv, {6'h28, ROWS[i].win, ROWS[i].left});
            rdchk(sacw_pkg::ADDR_RESULT_HIGH, ROWS[i].word[15:8]);
            rdchk(sacw_pkg::ADDR_RESULT_LOW, ROWS[i].word[7:0]);
        end
        repeat (20) @(posedge ref_clk);
        rdchk(CTL, 8'ha0);
        wr(CTL, 8'h80);
        rdchk(CTL, 8'h80);
        $display("result and window test done");
        wr(CFG, 8'h18);
        for (int s = 1; s < 4; s++) begin
            wr(CTL, {4'h8, s[1:0], 2'b00});
            wr(CTL, {4'h9, s[1:0], 2'b00});
            rdchk(CTL, {4'h8, s[1:0], 2'b00});
            fire(s);
            wait_done(60);
            external_convert_start = 1'b0;
        end
        $display("start source test done");
        wr(CFG, 8'h00);
        wr(CTL, 8'hc0);
        wr(CTL, 8'hd0);
        wait_done(40);
        wr(CFG, 8'h18);
        wr(CTL, 8'hc8);
        repeat (6) @(posedge ref_clk);
        #1;
        chk({7'h00, core_ctl.tracking}, 8'h01);
        fire(2);
        wait_done(60);
        chk({7'h00, core_ctl.tracking}, 8'h00);
        external_convert_start = 1'b0;
        $display("low-power test done");
        wr(CTL, 8'h80);
        wr(CTL, 8'h90);
        wr(CTL, 8'h00);
        repeat (80) @(posedge ref_clk);
        rdchk(CTL, 8'h00);
        wr(CTL, 8'h10);
        rdchk(CTL, 8'h00);
        chk({7'h00, core_ctl.sar_clk}, 8'h00);
        $display("shutdown test done");
        complete_run();
    end
endmodule

`default_nettype wire
